// ==== spifm_map.svh ====
`ifndef SPIFM_MAP_SVH
`define SPIFM_MAP_SVH
// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define SPIFM_OP_SET_WE   8'h06
`define SPIFM_OP_WR_DIS   8'h04
`define SPIFM_OP_RD_STAT  8'h05
`define SPIFM_OP_WR_STAT  8'h01
`define SPIFM_OP_MEM_RD   8'h03
`define SPIFM_OP_MEM_WR   8'h02
// ----------------------------------------------------------------------------
// Status byte layout and reset values
// ----------------------------------------------------------------------------
`define SPIFM_ST_WPEN     7
`define SPIFM_ST_BP_HI    3
`define SPIFM_ST_BP_LO    2
`define SPIFM_ST_WEL      1
`define SPIFM_ST_FIX_HI   2'h2
`define SPIFM_ST_FIX_MID  1'h0
`define SPIFM_ST_FIX_LO   1'h0
`define SPIFM_BP_RST      2'h0
`define SPIFM_WPEN_RST    1'h0
// ----------------------------------------------------------------------------
// Block protection codes and memory geometry
// ----------------------------------------------------------------------------
`define SPIFM_BP_NONE     2'h0
`define SPIFM_BP_QUARTER  2'h1
`define SPIFM_BP_HALF     2'h2
`define SPIFM_BP_ALL      2'h3
`define SPIFM_QUARTER_TOP 2'h3
`define SPIFM_MEM_DEPTH   65536
`define SPIFM_ADDR_ONE    16'h0001
// ----------------------------------------------------------------------------
// Framing
// ----------------------------------------------------------------------------
`define SPIFM_LAST_BIT    3'h7
`define SPIFM_BIT_ONE     3'h1
`define SPIFM_HDR_ADDR    17'h00003
`define SPIFM_HDR_PLAIN   17'h00001
`define SPIFM_HALF_DEF    3
`endif

// ==== spifm_pkg.sv ====
`default_nettype none
package spifm_pkg;
    typedef enum logic [2:0] {
        dev_cmd,
        dev_addr_hi,
        dev_addr_lo,
        dev_wr_data,
        dev_rd_data,
        dev_stat_in,
        dev_stat_out,
        dev_ignore
    } spifm_dev_state_e;

    typedef enum logic [1:0] {
        host_idle,
        host_shift,
        host_tail
    } spifm_host_state_e;
endpackage
`default_nettype wire

// ==== spifm_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface spifm_if;
    logic sck;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe_n;
    logic hold_n;
    logic wp_n;
    logic so_line;

    // The output line floats high through a pull-up when the device lets go.
    assign so_line = miso_oe_n ? 1'b1 : miso;

    modport device (
        input  sck,
        input  cs_n,
        input  mosi,
        input  hold_n,
        input  wp_n,
        output miso,
        output miso_oe_n
    );

    modport host (
        output sck,
        output cs_n,
        output mosi,
        output hold_n,
        output wp_n,
        input  so_line
    );
endinterface
`default_nettype wire

// ==== spifm_device.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "spifm_map.svh"
// How it works
// - Master enables writes in an earlier frame.
// - Write command then two address bytes.
// - Write bytes land at consecutive addresses.
// - Address counter wraps from top to zero.
// - Each byte stored after its eighth clock.
// - Chip select rise ends write; partial dropped.
// - Protect pin sampled only at frame start.
// - Read command then two address bytes.
// - Input line ignored after read header.
// - Read shifts eight bits, MSB first, increments.
// - Chip select rise ends read output.
// - Pause low with clock low freezes state.
// - Pause release resumes exactly where stopped.
// - Pause moves with clock low; toggles ignored.
// - Fixed eight-bit command code table.
// - Sample on rising edge, drive on falling.
// - Enable latch clears after disabling writes.
// - Block-protect bits suppress writes by range.
module spifm_device (
    spifm_if.device           link,
    input  wire logic         sys_rst_i,
    output logic [7:0]        status_o
);
    // ------------------------------------------------------------------------
    // Storage and state
    // ------------------------------------------------------------------------
    logic [7:0]                   mem [0:`SPIFM_MEM_DEPTH-1];
    spifm_pkg::spifm_dev_state_e  state;
    logic [2:0]                   bit_cnt;
    logic [6:0]                   sh;
    logic [15:0]                  addr;
    logic                         is_read;
    logic [7:0]                   tx_byte;
    logic                         tx_on;
    logic                         write_enable_latch;
    logic                         wel_clr_pend;
    logic                         wpen;
    logic [1:0]                   bp;
    logic                         wp_lat;
    logic                         frame_rst;
    logic [7:0]                   rx_byte;
    logic                         byte_end;
    logic                         first_edge;
    logic                         prot;
    logic                         mem_we;
    logic                         stat_we;
    logic [7:0]                   status_byte;

    // ------------------------------------------------------------------------
    // Framing helpers
    // ------------------------------------------------------------------------
    // The frame logic is cleared by chip select going high, but a paused
    // frame must survive chip select toggling, so the pause masks it.
    assign frame_rst   = link.cs_n & link.hold_n;
    assign rx_byte     = {sh, link.mosi};
    assign byte_end    = link.hold_n & (bit_cnt == `SPIFM_LAST_BIT);
    assign first_edge  = (state == spifm_pkg::dev_cmd) & (bit_cnt == 3'h0);
    assign status_byte = {wpen, `SPIFM_ST_FIX_HI, `SPIFM_ST_FIX_MID, bp, write_enable_latch,
                          `SPIFM_ST_FIX_LO};
    assign status_o    = status_byte;

    // Protected ranges decoded from the two block-protect bits.
    always_comb begin
        case (bp)
            `SPIFM_BP_NONE:    prot = 1'b0;
            `SPIFM_BP_QUARTER: prot = (addr[15:14] == `SPIFM_QUARTER_TOP);
            `SPIFM_BP_HALF:    prot = addr[15];
            `SPIFM_BP_ALL:     prot = 1'b1;
            default:           prot = 1'b1;
        endcase
    end

    // Only whole bytes are stored; a byte cut short by chip select never
    // reaches its eighth edge and so never strobes the array.
    assign mem_we  = byte_end & (state == spifm_pkg::dev_wr_data)
                   & write_enable_latch & ~prot;
    assign stat_we = byte_end & (state == spifm_pkg::dev_stat_in)
                   & write_enable_latch & ~(wpen & ~wp_lat);

    // ------------------------------------------------------------------------
    // Bit counter and input shifter
    // ------------------------------------------------------------------------
    // Edges seen while paused are dropped, which freezes the frame.
    always_ff @(posedge link.sck or posedge frame_rst) begin
        if (frame_rst) begin
            bit_cnt <= 3'h0;
            sh      <= 7'h00;
        end else if (link.hold_n) begin
            bit_cnt <= bit_cnt + `SPIFM_BIT_ONE;
            sh      <= rx_byte[6:0];
        end
    end

    // ------------------------------------------------------------------------
    // Transaction sequencer
    // ------------------------------------------------------------------------
    // One command per frame: anything unknown or finished parks in ignore.
    always_ff @(posedge link.sck or posedge frame_rst) begin
        if (frame_rst) begin
            state   <= spifm_pkg::dev_cmd;
            is_read <= 1'b0;
        end else if (byte_end) begin
            case (state)
                spifm_pkg::dev_cmd: begin
                    case (rx_byte)
                        `SPIFM_OP_MEM_RD: begin
                            state   <= spifm_pkg::dev_addr_hi;
                            is_read <= 1'b1;
                        end
                        `SPIFM_OP_MEM_WR: begin
                            state   <= spifm_pkg::dev_addr_hi;
                            is_read <= 1'b0;
                        end
                        `SPIFM_OP_RD_STAT: state <= spifm_pkg::dev_stat_out;
                        `SPIFM_OP_WR_STAT: state <= spifm_pkg::dev_stat_in;
                        default:           state <= spifm_pkg::dev_ignore;
                    endcase
                end
                spifm_pkg::dev_addr_hi: state <= spifm_pkg::dev_addr_lo;
                spifm_pkg::dev_addr_lo: begin
                    state <= is_read ? spifm_pkg::dev_rd_data : spifm_pkg::dev_wr_data;
                end
                spifm_pkg::dev_stat_in: state <= spifm_pkg::dev_ignore;
                default:                state <= state;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Address counter
    // ------------------------------------------------------------------------
    // The counter is exactly sixteen bits, so passing the top wraps to zero.
    always_ff @(posedge link.sck or posedge frame_rst) begin
        if (frame_rst) begin
            addr <= 16'h0000;
        end else if (byte_end) begin
            case (state)
                spifm_pkg::dev_addr_hi: addr[15:8] <= rx_byte;
                spifm_pkg::dev_addr_lo: addr[7:0]  <= rx_byte;
                spifm_pkg::dev_wr_data: addr <= addr + `SPIFM_ADDR_ONE;
                spifm_pkg::dev_rd_data: addr <= addr + `SPIFM_ADDR_ONE;
                default:                addr <= addr;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Array write port
    // ------------------------------------------------------------------------
    // Stored on the eighth rising edge; there is no page buffer at all.
    always_ff @(posedge link.sck) begin
        if (mem_we) begin
            mem[addr] <= rx_byte;
        end
    end

    // ------------------------------------------------------------------------
    // Output byte fetch
    // ------------------------------------------------------------------------
    // The next byte is fetched on the last rising edge of the current one,
    // leaving half a clock before its first bit must appear. The input line
    // plays no part once the read header is done.
    always_ff @(posedge link.sck or posedge frame_rst) begin
        if (frame_rst) begin
            tx_byte <= 8'h00;
        end else if (byte_end) begin
            case (state)
                spifm_pkg::dev_cmd:      tx_byte <= status_byte;
                spifm_pkg::dev_stat_out: tx_byte <= status_byte;
                spifm_pkg::dev_addr_lo:  tx_byte <= mem[{addr[15:8], rx_byte}];
                spifm_pkg::dev_rd_data: begin
                    tx_byte <= mem[addr + `SPIFM_ADDR_ONE];
                end
                default:                 tx_byte <= tx_byte;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Output shifter on the falling edge
    // ------------------------------------------------------------------------
    always_ff @(negedge link.sck or posedge frame_rst) begin
        if (frame_rst) begin
            tx_on <= 1'b0;
            link.miso <= 1'b0;
        end else if (link.hold_n) begin
            tx_on <= (state == spifm_pkg::dev_rd_data) |
                     (state == spifm_pkg::dev_stat_out);
            link.miso <= tx_byte[`SPIFM_LAST_BIT - bit_cnt];
        end
    end

    // The driver lets go at once on pause or deselect, without a clock.
    assign link.miso_oe_n = ~(tx_on & link.hold_n & ~link.cs_n);

    // ------------------------------------------------------------------------
    // Persistent status: enable latch, protection bits, protect pin sample
    // ------------------------------------------------------------------------
    // No clock runs at the chip select rising edge, so the latch clear that
    // belongs there is remembered and applied at the next frame's first edge,
    // before any command of that frame can observe the latch.
    always_ff @(posedge link.sck or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            write_enable_latch          <= 1'b0;
            wel_clr_pend <= 1'b0;
            wpen         <= `SPIFM_WPEN_RST;
            bp           <= `SPIFM_BP_RST;
            wp_lat       <= 1'b1;
        end else if (link.hold_n & ~link.cs_n) begin
            if (first_edge) begin
                wp_lat <= link.wp_n;
                if (wel_clr_pend) begin
                    write_enable_latch          <= 1'b0;
                    wel_clr_pend <= 1'b0;
                end
            end
            if (byte_end & (state == spifm_pkg::dev_cmd)) begin
                case (rx_byte)
                    `SPIFM_OP_SET_WE:  write_enable_latch <= 1'b1;
                    `SPIFM_OP_WR_DIS:  write_enable_latch <= 1'b0;
                    `SPIFM_OP_MEM_WR:  wel_clr_pend <= 1'b1;
                    `SPIFM_OP_WR_STAT: wel_clr_pend <= 1'b1;
                    default:           write_enable_latch <= write_enable_latch;
                endcase
            end
            if (stat_we) begin
                wpen <= rx_byte[`SPIFM_ST_WPEN];
                bp   <= rx_byte[`SPIFM_ST_BP_HI:`SPIFM_ST_BP_LO];
            end
        end
    end
endmodule
`default_nettype wire

// ==== spifm_host.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "spifm_map.svh"
module spifm_host #(
    parameter int HALF_DIV = `SPIFM_HALF_DEF
) (
    input  wire logic         clk_i,
    input  wire logic         sys_rst_i,
    spifm_if.host             link,
    input  wire logic         req_valid_i,
    output logic              req_ready_o,
    input  wire logic [7:0]   cmd_i,
    input  wire logic [15:0]  addr_i,
    input  wire logic [15:0]  len_i,
    input  wire logic [7:0]   tx_data_i,
    output logic              tx_take_o,
    output logic [7:0]        rx_data_o,
    output logic              rx_valid_o,
    output logic              done_o,
    input  wire logic         pause_i,
    input  wire logic         wp_n_i
);
    localparam logic [15:0] HALF_M1  = 16'(HALF_DIV - 1);
    localparam logic [15:0] TAIL_END = 16'(2 * HALF_DIV - 1);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    spifm_pkg::spifm_host_state_e  state;
    logic [15:0]                   cnt;
    logic [2:0]                    bit_idx;
    logic [16:0]                   byte_idx;
    logic [16:0]                   total;
    logic [16:0]                   hdr;
    logic [15:0]                   addr;
    logic [7:0]                    tx_sh;
    logic [7:0]                    rx_sh;
    logic                          so_s1;
    logic                          so_s2;
    logic                          stall;
    logic                          tick;
    logic                          with_addr;
    logic [16:0]                   nxt_idx;
    logic [7:0]                    nxt_byte;

    assign req_ready_o = (state == spifm_pkg::host_idle);
    assign with_addr   = (cmd_i == `SPIFM_OP_MEM_RD) | (cmd_i == `SPIFM_OP_MEM_WR);
    // Pause may only move while the clock is low, so a pause asked for in
    // the high half waits for the falling edge before it takes hold.
    assign stall       = ~link.sck & (pause_i | ~link.hold_n);
    assign tick        = (cnt == HALF_M1) & ~stall;
    assign nxt_idx     = byte_idx + 17'h00001;

    // Next byte to send: address bytes first when the command carries them.
    always_comb begin
        nxt_byte = tx_data_i;
        if (hdr == `SPIFM_HDR_ADDR && nxt_idx == 17'h00001) begin
            nxt_byte = addr[15:8];
        end else if (hdr == `SPIFM_HDR_ADDR && nxt_idx == 17'h00002) begin
            nxt_byte = addr[7:0];
        end
    end

    // ------------------------------------------------------------------------
    // Input synchroniser and pins that only follow the user side
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            so_s1       <= 1'b1;
            so_s2       <= 1'b1;
            link.wp_n   <= 1'b1;
            link.hold_n <= 1'b1;
        end else begin
            so_s1     <= link.so_line;
            so_s2     <= so_s1;
            link.wp_n <= wp_n_i;
            if (~link.sck) begin
                link.hold_n <= ~pause_i;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Frame sequencer and clock divider
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state      <= spifm_pkg::host_idle;
            cnt        <= 16'h0000;
            bit_idx    <= 3'h0;
            byte_idx   <= 17'h00000;
            total      <= 17'h00000;
            hdr        <= 17'h00000;
            addr       <= 16'h0000;
            tx_sh      <= 8'h00;
            rx_sh      <= 8'h00;
            rx_data_o  <= 8'h00;
            rx_valid_o <= 1'b0;
            tx_take_o  <= 1'b0;
            done_o     <= 1'b0;
            link.sck   <= 1'b0;
            link.cs_n  <= 1'b1;
            link.mosi  <= 1'b0;
        end else begin
            rx_valid_o <= 1'b0;
            tx_take_o  <= 1'b0;
            done_o     <= 1'b0;
            case (state)
                spifm_pkg::host_idle: begin
                    if (req_valid_i) begin
                        hdr       <= with_addr ? `SPIFM_HDR_ADDR : `SPIFM_HDR_PLAIN;
                        total     <= (with_addr ? `SPIFM_HDR_ADDR : `SPIFM_HDR_PLAIN)
                                     + {1'b0, len_i};
                        addr      <= addr_i;
                        tx_sh     <= cmd_i;
                        link.mosi <= cmd_i[7];
                        link.cs_n <= 1'b0;
                        cnt       <= 16'h0000;
                        bit_idx   <= 3'h0;
                        byte_idx  <= 17'h00000;
                        state     <= spifm_pkg::host_shift;
                    end
                end
                spifm_pkg::host_shift: begin
                    // A pause restarts the half period, so the first rise after it
                    // samples the output only once the synchroniser has caught up.
                    if (~link.hold_n) begin
                        cnt <= 16'h0000;
                    end else if (~stall) begin
                        cnt <= tick ? 16'h0000 : cnt + 16'h0001;
                    end
                    if (tick & ~link.sck) begin
                        link.sck <= 1'b1;
                        rx_sh    <= {rx_sh[6:0], so_s2};
                    end else if (tick) begin
                        link.sck <= 1'b0;
                        bit_idx  <= bit_idx + `SPIFM_BIT_ONE;
                        if (bit_idx == `SPIFM_LAST_BIT) begin
                            rx_data_o  <= rx_sh;
                            rx_valid_o <= (byte_idx >= hdr);
                            if (nxt_idx == total) begin
                                state <= spifm_pkg::host_tail;
                            end else begin
                                tx_sh     <= nxt_byte;
                                link.mosi <= nxt_byte[7];
                                byte_idx  <= nxt_idx;
                                tx_take_o <= (nxt_idx >= hdr);
                            end
                        end else begin
                            tx_sh     <= {tx_sh[6:0], 1'b0};
                            link.mosi <= tx_sh[6];
                        end
                    end
                end
                spifm_pkg::host_tail: begin
                    cnt <= cnt + 16'h0001;
                    if (cnt == HALF_M1) begin
                        link.cs_n <= 1'b1;
                    end
                    if (cnt == TAIL_END) begin
                        done_o <= 1'b1;
                        state  <= spifm_pkg::host_idle;
                    end
                end
                default: state <= spifm_pkg::host_idle;
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== spifm_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Link watcher
// ------------------------------
// Sampled on the system clock, which is well above the link rate.
module spifm_asserts (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe_n,
    input wire logic hold_n
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    // A frame opens, and the output stays released for eight system clocks, starting with the one that sees the fall.
    sequence s_open;
        $fell(cs_n);
    endsequence
    sequence s_quiet;
        miso_oe_n [*8];
    endsequence
    chk_sck_idle: assert property (cs_n |-> !sck)
        else $error("link clock not idle low between frames");
    chk_open_low: assert property (s_open |-> !sck [*3])
        else $error("link clock left low too briefly after select");
    chk_open_quiet: assert property (s_open |-> s_quiet)
        else $error("output driven during command byte");
    chk_cs_release: assert property (cs_n |-> miso_oe_n)
        else $error("output driven while deselected");
    chk_pause_release: assert property (!hold_n |-> miso_oe_n)
        else $error("output driven while paused");
    chk_miso_hold: assert property (sck && $past(sck) && !miso_oe_n |-> $stable(miso))
        else $error("output moved while link clock high");
    chk_mosi_hold: assert property (sck && $past(sck) |-> $stable(mosi))
        else $error("input line moved while link clock high");
    chk_pause_edge: assert property ($changed(hold_n) |-> !sck)
        else $error("pause moved while link clock high");
    chk_pause_freeze: assert property ((!hold_n ##1 !hold_n) |-> $stable(sck))
        else $error("link clock moved while paused");
    chk_cs_gap: assert property ($rose(cs_n) |-> cs_n [*3])
        else $error("deselect gap too short");
endmodule
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "spifm_map.svh"
// ------------------------------
// Bench
// ------------------------------
module testbench;
    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        req_valid_i = 1'b0;
    logic        req_ready_o, tx_take_o, rx_valid_o, done_o;
    logic [7:0]  cmd_i = 8'h00;
    logic [15:0] addr_i = 16'h0000;
    logic [15:0] len_i = 16'h0000;
    logic [7:0]  tx_data_i = 8'h00;
    logic [7:0]  rx_data_o, status_o;
    logic        pause_i = 1'b0;
    logic        wp_n_i = 1'b1;
    logic [7:0]  wbuf [4];
    logic [7:0]  rbuf [4];
    int          bad_count = 0;
    int          checks_done = 0;
    spifm_if link ();
    spifm_host spifm_host_inst (.clk_i, .sys_rst_i, .link, .req_valid_i, .req_ready_o, .cmd_i,
        .addr_i, .len_i, .tx_data_i, .tx_take_o, .rx_data_o, .rx_valid_o, .done_o, .pause_i,
        .wp_n_i);
    spifm_device spifm_device_inst (.link, .sys_rst_i, .status_o);
    spifm_asserts spifm_asserts_inst (.clk_i, .sys_rst_i, .sck(link.sck), .cs_n(link.cs_n),
        .mosi(link.mosi), .miso(link.miso), .miso_oe_n(link.miso_oe_n), .hold_n(link.hold_n));
    // The system clock; the link clock is divided down from it inside the host.
    always #25 clk_i = ~clk_i;
    task automatic wrap_up;
        if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask
    // One whole frame; a pause is held for 60 cycles when pause_at is reached.
    task automatic run(input logic [7:0] cmd, input logic [15:0] addr, input logic [15:0] len,
                       input int pause_at);
        int n;
        int ti;
        int ri;
        ti = 0;
        ri = 0;
        @(negedge clk_i);
        cmd_i = cmd;
        addr_i = addr;
        len_i = len;
        tx_data_i = wbuf[0];
        req_valid_i = 1'b1;
        @(negedge clk_i);
        req_valid_i = 1'b0;
        check8("ready busy", 8'h00, {7'h00, req_ready_o});
        for (n = 0; n < 3000 && done_o !== 1'b1; n++) begin
            @(negedge clk_i);
            if (tx_take_o === 1'b1) begin
                ti++;
                tx_data_i = wbuf[ti%4];
            end
            if (rx_valid_o === 1'b1) begin
                rbuf[ri%4] = rx_data_o;
                ri++;
            end
            if (n == pause_at) pause_i = 1'b1;
            if (n == pause_at + 30) check8("paused line", 8'h01, {7'h00, link.so_line});
            if (n == pause_at + 60) pause_i = 1'b0;
        end
        if (n >= 3000) begin
            bad_count++;
            wrap_up();
        end
        check8("ready idle", 8'h01, {7'h00, req_ready_o});
    endtask
    task automatic wen;
        run(`SPIFM_OP_SET_WE, 16'h0000, 16'h0000, 9999);
    endtask
    // Writing across the top address must wrap; a read follows the same path.
    task automatic t_wrap;
        wbuf = '{8'h11, 8'h22, 8'h33, 8'h44};
        wen();
        run(`SPIFM_OP_MEM_WR, 16'hFFFE, 16'h0004, 9999);
        run(`SPIFM_OP_MEM_RD, 16'hFFFF, 16'h0003, 9999);
        check8("rd FFFF", 8'h22, rbuf[0]);
        check8("rd 0000", 8'h33, rbuf[1]);
        check8("rd 0001", 8'h44, rbuf[2]);
        check8("wel", 8'h00, {7'h00, status_o[`SPIFM_ST_WEL]});
    endtask
    // A second write without a fresh enable must leave the byte alone.
    task automatic t_no_wel;
        wbuf = '{8'h3C, 8'h00, 8'h00, 8'h00};
        wen();
        check8("wel set", 8'h01, {7'h00, status_o[`SPIFM_ST_WEL]});
        run(`SPIFM_OP_WR_DIS, 16'h0000, 16'h0000, 9999);
        check8("wel off", 8'h00, {7'h00, status_o[`SPIFM_ST_WEL]});
        wen();
        run(`SPIFM_OP_MEM_WR, 16'h0010, 16'h0001, 9999);
        wbuf[0] = 8'hC3;
        run(`SPIFM_OP_MEM_WR, 16'h0010, 16'h0001, 9999);
        run(`SPIFM_OP_MEM_RD, 16'h0010, 16'h0001, 9999);
        check8("rd 0010", 8'h3C, rbuf[0]);
    endtask
    // Pauses land in the address of a write and in the data of a read.
    task automatic t_pause;
        wbuf = '{8'h5A, 8'hA5, 8'h0F, 8'hF0};
        wen();
        run(`SPIFM_OP_MEM_WR, 16'h0100, 16'h0002, 100);
        run(`SPIFM_OP_MEM_RD, 16'h0100, 16'h0002, 200);
        check8("rd 0100", 8'h5A, rbuf[0]);
        check8("rd 0101", 8'hA5, rbuf[1]);
    endtask
    // Upper-quarter protection: BFFF takes the write, C000 keeps its byte.
    task automatic t_protect;
        wbuf = '{8'h5A, 8'hA5, 8'hA5, 8'hA5};
        wen();
        run(`SPIFM_OP_MEM_WR, 16'hC000, 16'h0001, 9999);
        wbuf[0] = 8'h04;
        wen();
        run(`SPIFM_OP_WR_STAT, 16'h0000, 16'h0001, 9999);
        check8("bp", 8'h04, status_o & 8'h0C);
        run(`SPIFM_OP_RD_STAT, 16'h0000, 16'h0001, 9999);
        check8("status", 8'h44, rbuf[0]);
        wbuf[0] = 8'hA5;
        wen();
        run(`SPIFM_OP_MEM_WR, 16'hBFFF, 16'h0002, 9999);
        run(`SPIFM_OP_MEM_RD, 16'hBFFF, 16'h0002, 9999);
        check8("rd BFFF", 8'hA5, rbuf[0]);
        check8("rd C000", 8'h5A, rbuf[1]);
    endtask
    // The status byte is locked only while its lock bit is set and the pin is low.
    task automatic t_wp;
        wbuf[0] = 8'h80;
        wen();
        run(`SPIFM_OP_WR_STAT, 16'h0000, 16'h0001, 9999);
        wp_n_i = 1'b0;
        wbuf[0] = 8'h0C;
        wen();
        run(`SPIFM_OP_WR_STAT, 16'h0000, 16'h0001, 9999);
        check8("locked", 8'h80, status_o & 8'h8C);
        wp_n_i = 1'b1;
        wen();
        run(`SPIFM_OP_WR_STAT, 16'h0000, 16'h0001, 9999);
        check8("unlocked", 8'h0C, status_o & 8'h8C);
    endtask
    initial begin
        repeat (10) @(negedge clk_i);
        sys_rst_i = 1'b0;
        t_wrap();
        t_no_wel();
        t_pause();
        t_protect();
        t_wp();
        wrap_up();
    end
endmodule
`default_nettype wire
